// ---- rtl/pbs_fifo.sv ----
`timescale 1ns/10ps
module pbs_fifo #(
  parameter int unsigned WIDTH = 46,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : pbs_fifo

// ---- rtl/pbs_pkg.sv ----
// How it works
// - Load/advance high on an enabled edge steps the burst counter unless deselected.
// - Load/advance low on an enabled edge loads a fresh address.
// - Inputs are captured only on edges with the clock gate low.
// - Clock gate high freezes state, selection and output pipeline.
// - Selected when select one low, select two high, select three low.
// - Output enable low lets data pins drive; high three-states them.
// - Pins three-state in write data phase, after deselect, when deselected.
// - Read data is registered on its address edge and appears right after that edge.
// - Data pins are loaded into the write-data register on the edge.
// - Each parity bit acts as a data bit of its byte lane.
// - Burst-order strap high gives interleaved order, low gives linear.
// - Low byte-write selects with the write strobe write their lanes only.
// - Write strobe low on a selected load starts a write, else a read.
// - Sleep input stops activity while keeping stored contents.
package pbs_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DEPTH = 64;
  localparam int unsigned LANES = 4;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned WORD_W = 36;
  localparam int unsigned BURST_W = 2;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned ENTRY_W = 46;
  localparam int unsigned ENT_DATA_LSB = 0;
  localparam int unsigned ENT_PAR_LSB = 32;
  localparam int unsigned ENT_MASK_LSB = 36;
  localparam int unsigned ENT_ADDR_LSB = 40;
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [35:0] RD_RST = 36'h0;
  typedef enum logic [1:0] {
    ST_DESEL,
    ST_READ,
    ST_WRITE
  } pbs_state_t;
endpackage : pbs_pkg

// ---- rtl/pbs_port.sv ----
`timescale 1ns/10ps
module pbs_port (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Control inputs
  input wire logic clock_gate_n_i,
  input wire logic load_or_advance_i,
  input wire logic chip_select_one_n_i,
  input wire logic chip_select_two_i,
  input wire logic chip_select_three_n_i,
  input wire logic write_n_i,
  input wire logic [pbs_pkg::LANES-1:0] byte_write_select_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_order_i,
  input wire logic [pbs_pkg::ADDR_W-1:0] address_i,
  // Data lanes
  input wire logic [pbs_pkg::DATA_W-1:0] data_i,
  output logic [pbs_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [pbs_pkg::LANES-1:0] parity_lane_i,
  output logic [pbs_pkg::LANES-1:0] parity_lane_o,
  output logic parity_lane_oe_o,
  // Write buffer status
  output logic write_ready_o
);
  localparam int unsigned HI_W = pbs_pkg::ADDR_W - pbs_pkg::BURST_W;

  pbs_pkg::pbs_state_t state_q;
  logic [HI_W-1:0] base_q;
  logic [pbs_pkg::BURST_W-1:0] start_q;
  logic [pbs_pkg::BURST_W-1:0] cnt_q;
  logic [pbs_pkg::BURST_W-1:0] cnt_nxt;
  logic [pbs_pkg::BURST_W-1:0] low_nxt;
  logic [pbs_pkg::WORD_W-1:0] mem_q [pbs_pkg::DEPTH];
  logic [pbs_pkg::WORD_W-1:0] rd_q;
  logic rd_phase_q;
  logic wr_phase_q;
  logic [pbs_pkg::ADDR_W-1:0] wr_addr_q;
  logic [pbs_pkg::LANES-1:0] wr_mask_n_q;
  logic enabled;
  logic selected;
  logic load;
  logic advance;
  logic adv_rd;
  logic adv_wr;
  logic rd_now;
  logic wr_now;
  logic [pbs_pkg::ADDR_W-1:0] acc_addr;
  logic push;
  logic [pbs_pkg::ENTRY_W-1:0] push_data;
  logic drain_valid;
  logic drain_ready;
  logic [pbs_pkg::ENTRY_W-1:0] drain_data;
  logic [pbs_pkg::ADDR_W-1:0] drain_addr;
  logic [pbs_pkg::LANES-1:0] drain_mask_n;
  logic [pbs_pkg::LANES-1:0] drain_par;
  logic [pbs_pkg::WORD_W-1:0] drain_word;

  // Edge qualification and decode
  assign enabled = ~clock_gate_n_i & ~sleep_request_i;
  assign selected = ~chip_select_one_n_i & chip_select_two_i
    & ~chip_select_three_n_i;
  assign load = enabled & ~load_or_advance_i;
  assign advance = enabled & load_or_advance_i
    & (state_q != pbs_pkg::ST_DESEL);

  // A burst continues the kind of access that its load started
  always_comb begin
    adv_rd = 1'b0;
    adv_wr = 1'b0;
    case (state_q)
      pbs_pkg::ST_READ: begin
        adv_rd = advance;
      end
      pbs_pkg::ST_WRITE: begin
        adv_wr = advance;
      end
      pbs_pkg::ST_DESEL: begin
        adv_rd = 1'b0;
        adv_wr = 1'b0;
      end
      default: begin
        adv_rd = 1'b0;
        adv_wr = 1'b0;
      end
    endcase
  end

  assign rd_now = (load & selected & write_n_i)
    | adv_rd;
  assign wr_now = (load & selected & ~write_n_i)
    | adv_wr;

  // Burst sequence over the two low address bits
  assign cnt_nxt = cnt_q + 2'h1;
  always_comb begin
    if (burst_order_i) begin
      low_nxt = start_q ^ cnt_nxt;
    end else begin
      low_nxt = start_q + cnt_nxt;
    end
  end

  // Load edges take the pins; advance edges take the next burst beat
  always_comb begin
    if (load) begin
      acc_addr = address_i;
    end else begin
      acc_addr = {base_q, low_nxt};
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= pbs_pkg::ST_DESEL;
    end else if (load) begin
      if (!selected) begin
        state_q <= pbs_pkg::ST_DESEL;
      end else if (write_n_i) begin
        state_q <= pbs_pkg::ST_READ;
      end else begin
        state_q <= pbs_pkg::ST_WRITE;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_q <= '0;
      start_q <= pbs_pkg::CNT_RST;
      cnt_q <= pbs_pkg::CNT_RST;
    end else if (load && selected) begin
      base_q <= address_i[pbs_pkg::ADDR_W-1:pbs_pkg::BURST_W];
      start_q <= address_i[pbs_pkg::BURST_W-1:0];
      cnt_q <= pbs_pkg::CNT_RST;
    end else if (advance) begin
      cnt_q <= cnt_nxt;
    end
  end

  // Read pipeline: data is registered on its address edge itself
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_q <= pbs_pkg::RD_RST;
    end else if (rd_now) begin
      rd_q <= mem_q[acc_addr];
    end
  end

  // Drive window: opened by a read edge, closed by any other recognised edge
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_phase_q <= 1'b0;
    end else if (enabled) begin
      rd_phase_q <= rd_now;
    end
  end

  assign data_o = rd_q[pbs_pkg::DATA_W-1:0];
  assign parity_lane_o = rd_q[pbs_pkg::WORD_W-1:pbs_pkg::DATA_W];
  assign data_oe_o = rd_phase_q & ~output_enable_n_i
    & ~sleep_request_i;
  assign parity_lane_oe_o = data_oe_o;

  // Write address phase: address and byte selects held for data phase
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_phase_q <= 1'b0;
      wr_addr_q <= '0;
      wr_mask_n_q <= '1;
    end else if (enabled) begin
      wr_phase_q <= wr_now;
      if (wr_now) begin
        wr_addr_q <= acc_addr;
        wr_mask_n_q <= byte_write_select_n_i;
      end
    end
  end

  // Write data phase: pins captured straight into the buffer
  assign push = enabled & wr_phase_q;
  always_comb begin
    push_data = '0;
    push_data[pbs_pkg::ENT_DATA_LSB +: pbs_pkg::DATA_W] = data_i;
    push_data[pbs_pkg::ENT_PAR_LSB +: pbs_pkg::LANES] = parity_lane_i;
    push_data[pbs_pkg::ENT_MASK_LSB +: pbs_pkg::LANES] = wr_mask_n_q;
    push_data[pbs_pkg::ENT_ADDR_LSB +: pbs_pkg::ADDR_W] = wr_addr_q;
  end

  // Array is single ported: a read edge holds off the drain
  assign drain_ready = ~sleep_request_i & ~rd_now;
  assign drain_addr = drain_data[pbs_pkg::ENT_ADDR_LSB +: pbs_pkg::ADDR_W];
  assign drain_mask_n = drain_data[pbs_pkg::ENT_MASK_LSB +: pbs_pkg::LANES];
  assign drain_word = drain_data[pbs_pkg::WORD_W-1:0];
  assign drain_par = drain_data[pbs_pkg::ENT_PAR_LSB +: pbs_pkg::LANES];

  // A push while the buffer is full is dropped; the host watches ready
  pbs_fifo #(
    .WIDTH(pbs_pkg::ENTRY_W),
    .DEPTH(pbs_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(push),
    .in_ready_o(write_ready_o),
    .in_data_i(push_data),
    .out_valid_o(drain_valid),
    .out_ready_i(drain_ready),
    .out_data_o(drain_data)
  );

  // Lane-masked commit; parity bit rides with its byte
  always_ff @(posedge ref_clk_i) begin
    if (drain_valid && drain_ready) begin
      for (int l = 0; l < int'(pbs_pkg::LANES); l++) begin
        if (!drain_mask_n[l]) begin
          mem_q[drain_addr][l*pbs_pkg::BYTE_W +: pbs_pkg::BYTE_W] <=
            drain_word[l*pbs_pkg::BYTE_W +: pbs_pkg::BYTE_W];
          mem_q[drain_addr][pbs_pkg::DATA_W + l] <=
            drain_par[l];
        end
      end
    end
  end
endmodule : pbs_port

// ---- tb/pbs_ctrl_model.sv ----
`timescale 1ns/10ps
module pbs_ctrl_model (
  // Clock
  input wire logic ref_clk_i,
  // Port controls
  output logic gate_n_o,
  output logic ld_o,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic [3:0] lane_sel_n_o,
  output logic [5:0] addr_o,
  output logic [35:0] wd_o
);
  initial begin
    {gate_n_o, ld_o, cs_n_o, wr_n_o} = 4'h3;
    {lane_sel_n_o, addr_o, wd_o} = '0;
  end
  // Data lines show the inverse of their last value when not writing
  task automatic step(input logic g, ld, cs, wn, input logic [3:0] lane_n,
    input logic [5:0] a, input logic [35:0] wd, input logic dv);
    @(posedge ref_clk_i);
    gate_n_o <= g;
    ld_o <= ld;
    cs_n_o <= cs;
    wr_n_o <= wn;
    lane_sel_n_o <= lane_n;
    addr_o <= a;
    wd_o <= dv ? wd : ~wd_o;
  endtask : step
endmodule : pbs_ctrl_model

// ---- tb/pbs_port_chk_asserts.sv ----
`timescale 1ns/10ps
module pbs_port_chk (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // Controls
  input wire logic clock_gate_n_i,
  input wire logic load_or_advance_i,
  input wire logic chip_select_one_n_i,
  input wire logic chip_select_two_i,
  input wire logic chip_select_three_n_i,
  input wire logic write_n_i,
  input wire logic output_enable_n_i,
  input wire logic sleep_request_i,
  // Outputs
  input wire logic [pbs_pkg::DATA_W-1:0] data_o,
  input wire logic data_oe_o,
  input wire logic parity_lane_oe_o
);
  logic rec;
  logic sel;
  logic ld;
  assign rec = !clock_gate_n_i && !sleep_request_i;
  assign sel = !chip_select_one_n_i && chip_select_two_i &&
    !chip_select_three_n_i;
  assign ld = rec && !load_or_advance_i;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_lane_oe_match: assert property (data_oe_o == parity_lane_oe_o)
    else $error("parity enable differs from data enable");
  a_oe_pin_off: assert property (output_enable_n_i |-> !data_oe_o)
    else $error("driving with output enable high");
  a_sleep_quiet: assert property (sleep_request_i |-> !data_oe_o)
    else $error("driving while asleep");
  a_freeze_hold: assert property (!rec |=> $stable(data_o))
    else $error("read data moved on an ignored edge");
  a_frozen_drive: assert property (ld && sel && write_n_i ##1
    (clock_gate_n_i && !sleep_request_i && !output_enable_n_i) |-> data_oe_o)
    else $error("drive lost while clock gated");
  a_read_drive: assert property (ld && sel && write_n_i |=>
    output_enable_n_i || sleep_request_i || data_oe_o)
    else $error("read data not driven");
  a_desel_quiet: assert property (ld && !sel |=> !data_oe_o)
    else $error("driving after deselect");
  a_write_quiet: assert property (ld && sel && !write_n_i |=>
    !data_oe_o)
    else $error("driving in write data phase");
  c_read: cover property (ld && sel && write_n_i ##1 data_oe_o);
  c_write: cover property (ld && sel && !write_n_i);
  c_freeze: cover property (data_oe_o && clock_gate_n_i);
endmodule : pbs_port_chk

bind pbs_port pbs_port_chk u_chk (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .clock_gate_n_i(clock_gate_n_i),
  .load_or_advance_i(load_or_advance_i),
  .chip_select_one_n_i(chip_select_one_n_i),
  .chip_select_two_i(chip_select_two_i),
  .chip_select_three_n_i(chip_select_three_n_i),
  .write_n_i(write_n_i),
  .output_enable_n_i(output_enable_n_i),
  .sleep_request_i(sleep_request_i),
  .data_o(data_o),
  .data_oe_o(data_oe_o),
  .parity_lane_oe_o(parity_lane_oe_o)
);

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic ref_clk_i, resetn_i, clock_gate_n_i, load_or_advance_i;
  logic chip_select_one_n_i, chip_select_two_i, chip_select_three_n_i;
  logic write_n_i, output_enable_n_i, sleep_request_i, burst_order_i;
  logic cs_n, data_oe_o, parity_lane_oe_o, write_ready_o;
  logic [2:0] cs_twist;
  logic [3:0] byte_write_select_n_i, parity_lane_i, parity_lane_o;
  logic [5:0] address_i;
  logic [31:0] data_i, data_o;
  logic [35:0] wd, mem [64];
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  assign chip_select_one_n_i = cs_n ^ cs_twist[0];
  assign chip_select_two_i = !cs_n ^ cs_twist[1];
  assign chip_select_three_n_i = cs_n ^ cs_twist[2];
  assign data_i = wd[31:0];
  assign parity_lane_i = wd[35:32];
  pbs_ctrl_model u_ctrl (.ref_clk_i(ref_clk_i), .gate_n_o(clock_gate_n_i),
    .ld_o(load_or_advance_i), .cs_n_o(cs_n), .wr_n_o(write_n_i),
    .lane_sel_n_o(byte_write_select_n_i), .addr_o(address_i), .wd_o(wd));
  pbs_port u_dut (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .clock_gate_n_i(clock_gate_n_i),
    .load_or_advance_i(load_or_advance_i),
    .chip_select_one_n_i(chip_select_one_n_i),
    .chip_select_two_i(chip_select_two_i),
    .chip_select_three_n_i(chip_select_three_n_i),
    .write_n_i(write_n_i),
    .byte_write_select_n_i(byte_write_select_n_i),
    .output_enable_n_i(output_enable_n_i),
    .sleep_request_i(sleep_request_i),
    .burst_order_i(burst_order_i),
    .address_i(address_i),
    .data_i(data_i),
    .data_o(data_o),
    .data_oe_o(data_oe_o),
    .parity_lane_i(parity_lane_i),
    .parity_lane_o(parity_lane_o),
    .parity_lane_oe_o(parity_lane_oe_o),
    .write_ready_o(write_ready_o)
  );
  initial ref_clk_i = 1'b0;
  always #2.5 ref_clk_i = !ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [35:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic check_flag(input string what, input logic exp, got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : check_flag
  function automatic logic [5:0] nxt(input logic [5:0] a, logic [1:0] n);
    return burst_order_i ? a ^ {4'h0, n} : {a[5:2], a[1:0] + n};
  endfunction : nxt
  function automatic logic [35:0] pat(input logic [5:0] a);
    return {a[3:0], {4{2'h1, a}}};
  endfunction : pat
  task automatic idle(input int n);
    repeat (n) u_ctrl.step(0, 0, 1, 1, 4'hf, 6'h0, 36'h0, 0);
  endtask : idle
  task automatic write_burst(input logic [5:0] a0);
    for (int n = 0; n < 5; n++) begin
      u_ctrl.step(0, n > 0 && n < 4, n == 4, n == 4, 4'h0, nxt(a0, 2'(n)),
        pat(nxt(a0, 2'(n - 1))), n > 0);
      #1 check_flag("write oe", 1'b0, data_oe_o);
      if (n > 0) mem[nxt(a0, 2'(n - 1))] = pat(nxt(a0, 2'(n - 1)));
    end
    idle(10);
  endtask : write_burst
  task automatic read_burst(input logic [5:0] a0);
    for (int n = 0; n < 6; n++) begin
      u_ctrl.step(0, n > 0 && n < 4, n > 3, 1, 4'hf, a0, 36'h0, 0);
      #1 check_flag("read oe", n > 0 && n < 5, data_oe_o);
      if (n > 0 && n < 5)
        check("read word", mem[nxt(a0, 2'(n - 1))],
          {parity_lane_o, data_o});
    end
  endtask : read_burst
  task automatic masked_write();
    u_ctrl.step(0, 0, 0, 0, 4'h5, 6'h05, 36'h0, 0);
    u_ctrl.step(0, 0, 1, 1, 4'hf, 6'h0, 36'hfffffffff, 1);
    mem[5] = {1'b1, mem[5][34], 1'b1, mem[5][32], 8'hff, mem[5][23:16],
      8'hff, mem[5][7:0]};
    idle(10);
  endtask : masked_write
  task automatic freeze_and_enables();
    u_ctrl.step(0, 0, 0, 1, 4'hf, 6'h04, 36'h0, 0);
    repeat (2) u_ctrl.step(1, 1, 0, 1, 4'hf, 6'h04, 36'h0, 0);
    output_enable_n_i <= 1'b1;
    #1 check("held word", mem[4], {parity_lane_o, data_o});
    check_flag("oe blocked", 1'b0, data_oe_o);
    u_ctrl.step(1, 1, 0, 1, 4'hf, 6'h04, 36'h0, 0);
    output_enable_n_i <= 1'b0;
    sleep_request_i <= 1'b1;
    #1 check_flag("sleep oe", 1'b0, data_oe_o);
    u_ctrl.step(0, 0, 1, 1, 4'hf, 6'h0, 36'h0, 0);
    sleep_request_i <= 1'b0;
    #1 check_flag("kept drive", 1'b1, data_oe_o);
    check("kept word", mem[4], {parity_lane_o, data_o});
    idle(2);
    #1 check_flag("desel oe", 1'b0, data_oe_o);
  endtask : freeze_and_enables
  // Each select alone turned off must deselect a read load
  task automatic select_combos();
    for (int k = 1; k < 5; k = k * 2) begin
      repeat (2) u_ctrl.step(0, 0, 0, 1, 4'hf, 6'h04, 36'h0, 0);
      cs_twist <= 3'(k);
      #1 check_flag("select oe", 1'b1, data_oe_o);
      idle(1);
      cs_twist <= 3'h0;
      #1 check_flag("part select oe", 1'b0, data_oe_o);
    end
  endtask : select_combos
  initial begin
    resetn_i = 1'b0;
    output_enable_n_i = 1'b0;
    sleep_request_i = 1'b0;
    burst_order_i = 1'b0;
    cs_twist = 3'h0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    #1 check_flag("ready", 1'b1, write_ready_o);
    write_burst(6'h05);
    read_burst(6'h06);
    burst_order_i <= 1'b1;
    read_burst(6'h05);
    masked_write();
    read_burst(6'h05);
    freeze_and_enables();
    select_combos();
    report_and_stop();
  end
endmodule : tb_top
